// ### pkg/vcard_pkg.sv
package vcard_pkg;

	// command codes
	localparam logic [7:0] CMD_READ_ONE = 8'h20;
	localparam logic [7:0] CMD_WRITE_ONE = 8'h21;
	localparam logic [7:0] CMD_READ_MULTI = 8'h23;
	localparam logic [7:0] CMD_SELECT = 8'h25;

	// request flag bit positions
	localparam int FLAG_INVENTORY = 2;
	localparam int FLAG_EXTEND = 3;
	localparam int FLAG_SELECT = 4;
	localparam int FLAG_ADDRESS = 5;
	localparam int FLAG_OPTION = 6;

	// response flags and error codes
	localparam logic [7:0] RSP_OK = 8'h00;
	localparam logic [7:0] RSP_ERR = 8'h01;
	localparam logic [7:0] ERR_OPTION = 8'h03;
	localparam logic [7:0] ERR_OTHER = 8'h0f;
	localparam logic [7:0] ERR_ABSENT = 8'h10;
	localparam logic [7:0] ERR_LOCKED = 8'h12;
	localparam logic [7:0] ERR_PROG = 8'h13;
	localparam logic [7:0] ERR_RPROT = 8'h15;

	// frame check
	localparam logic [15:0] CRC_PRESET = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_GOOD = 16'hf0b8;

	// memory geometry
	localparam logic [15:0] LAST_BLOCK = 16'h01ff;
	localparam logic [8:0] SECTOR_LAST = 9'h01f;

	// request layout and lengths (crc included, uid excluded except in select)
	localparam int REQ_MAX = 18;
	localparam logic [4:0] POS_PLAIN = 5'h02;
	localparam logic [4:0] POS_UID = 5'h0a;
	localparam logic [4:0] UID_LEN = 5'h08;
	localparam logic [4:0] LEN_READ_ONE = 5'h06;
	localparam logic [4:0] LEN_WRITE_ONE = 5'h0a;
	localparam logic [4:0] LEN_READ_MULTI = 5'h07;
	localparam logic [4:0] LEN_SELECT = 5'h0c;

	// program cycle: nominal response delay plus 18 steps of 302 us
	localparam int CLK_PERIOD_NS = 10;
	localparam int NOMINAL_RESPONSE_DELAY_NS = 320900;
	localparam int PROG_STEP_NS = 302000;
	localparam int PROG_STEPS = 18;
	localparam int PROGRAM_CYCLE_TIME_NS =
		NOMINAL_RESPONSE_DELAY_NS + PROG_STEPS * PROG_STEP_NS;
	localparam int PROG_CYCLES = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {TAG_READY, TAG_SELECTED, TAG_QUIET} tag_e;

	typedef enum logic [3:0] {
		ST_IDLE, ST_RX, ST_CHECK, ST_EXEC, ST_FETCH, ST_LATCH,
		ST_GRAB, ST_SEND, ST_PROG
	} seq_e;

endpackage

// ### src/block_access_core.sv
// Summary of operation
// - read single block 20h returns the four data bytes of the block.
// - wide-address flag must be one; otherwise answer an error response.
// - option flag on reads inserts a security status byte before data.
// - status byte: bit0 lock, bits1-2 rw protect, bits3-4 password, rest 0.
// - single read errors: 0Fh other, 10h absent block, 15h read-protected block.
// - busy mode holds activity low from request start until response end.
// - write-in-progress mode leaves activity released for reads and select.
// - write single block 21h programs 32 data bits at 16-bit block number.
// - write response waits for program cycle; success is flags only.
// - write errors: 0Fh other, 10h absent, 12h locked, 13h program failed.
// - write-in-progress mode drives activity low during program cycle.
// - read multiple block 23h reads count plus one blocks from first block.
// - at most 32 blocks, one sector; crossing a sector returns an error.
// - block numbers 00h to 1FFh are accepted.
// - multi read sends per block optional status byte then 32 data bits.
// - multi read errors: 0Fh other, 10h absent, 15h read-protected.
// - select 25h with own uid enters or stays selected and responds.
// - select with foreign uid moves a selected tag to ready, no response.
// - select errors (03h option) only on uid match; state then unchanged.
// - a quiet tag receiving a matching select becomes selected.
// - activity output mode selectable between busy and write-in-progress.
//
`timescale 1ns/1ps
module block_access_core #(
	parameter int PROG_CYCLES = vcard_pkg::PROG_CYCLES
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// request bytes from the frame decoder
	input wire logic sof_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_valid_i,
	input wire logic eof_i,
	// response bytes to the frame encoder
	output logic [7:0] tx_byte_o,
	output logic tx_valid_o,
	output logic tx_last_o,
	input wire logic tx_ready_i,
	// tag identity and configuration
	input wire logic [63:0] uid_i,
	input wire logic wip_mode_i,
	input wire logic go_quiet_i,
	output vcard_pkg::tag_e tag_state_o,
	// block memory
	output logic [8:0] mem_addr_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [31:0] mem_wdata_o,
	input wire logic [31:0] mem_rdata_i,
	input wire logic mem_ok_i,
	// sector security for the sector of mem_addr_o
	output logic [3:0] sector_o,
	input wire logic sec_lock_i,
	input wire logic [1:0] sec_rw_i,
	input wire logic [1:0] sec_pwd_i,
	input wire logic read_deny_i,
	input wire logic write_deny_i,
	// activity pin, open drain
	output logic act_o,
	output logic act_oe_o
);
	import vcard_pkg::*;

	typedef struct packed {
		seq_e st;
		tag_e tag;
		logic [REQ_MAX-1:0][7:0] rx;
		logic [4:0] len;
		logic [15:0] crc;
		logic [7:0] cmd;
		logic opt;
		logic [8:0] blk;
		logic [4:0] left;
		logic head;
		logic [19:0] timer;
		logic [5:0][7:0] q;
		logic [2:0] qn;
		logic busy;
		logic act_oe;
		logic [7:0] tx_byte;
		logic tx_valid;
		logic tx_last;
		logic mem_rd;
		logic mem_wr;
		logic [31:0] wdata;
	} core_s;

	core_s cur;
	core_s nx;

	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
		begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic [47:0] reply(input logic [7:0] flags,
		input logic [7:0] code);
		return {32'h0, code, flags};
	endfunction

	logic [7:0] f;
	logic [7:0] cmd;
	logic addr_mode;
	logic [4:0] p;
	logic [15:0] bn;
	logic [4:0] want;
	logic uid_ok;
	logic drop;
	logic [9:0] run_end;
	logic [7:0] sec;
	logic [47:0] qd;

	always_comb
	begin
		nx = cur;
		nx.mem_rd = 1'b0;
		nx.mem_wr = 1'b0;
		f = cur.rx[0];
		cmd = cur.rx[1];
		addr_mode = f[FLAG_ADDRESS];
		// uid sits right after the command code when addressed
		p = addr_mode ? POS_UID : POS_PLAIN;
		bn = {cur.rx[p + 5'h01], cur.rx[p]};
		uid_ok = (cur.rx[9:2] == uid_i);
		want = 5'h00;
		drop = 1'b0;
		// the run starts at the requested block, not at the last one served
		run_end = {5'h00, bn[4:0]} + {2'b00, cur.rx[p + 5'h02]};
		// reserved bits stay zero
		sec = {3'b000, sec_pwd_i, sec_rw_i, sec_lock_i};
		qd = {16'h0, mem_rdata_i};
		if (go_quiet_i)
		begin
			nx.tag = TAG_QUIET;
		end
		unique case (cur.st)
		ST_IDLE:
		begin
			if (sof_i)
			begin
				nx.st = ST_RX;
				nx.busy = 1'b1;
				nx.len = 5'h00;
				nx.crc = CRC_PRESET;
			end
		end
		ST_RX:
		begin
			if (rx_valid_i)
			begin
				nx.crc = crc_step(cur.crc, rx_byte_i);
				if (cur.len < 5'(REQ_MAX))
				begin
					nx.rx[cur.len] = rx_byte_i;
					nx.len = cur.len + 5'h01;
				end
				else
				begin
					// oversize frame: poison the length so it is dropped
					nx.len = 5'h1f;
				end
			end
			if (eof_i)
			begin
				nx.st = ST_CHECK;
			end
		end
		ST_CHECK:
		begin
			nx.cmd = cmd;
			nx.opt = f[FLAG_OPTION];
			nx.head = 1'b1;
			nx.left = 5'h00;
			nx.qn = 3'h2;
			nx.blk = bn[8:0];
			nx.wdata = {cur.rx[p + 5'h05], cur.rx[p + 5'h04],
				cur.rx[p + 5'h03], cur.rx[p + 5'h02]};
			unique case (cmd)
			CMD_READ_ONE: want = LEN_READ_ONE;
			CMD_WRITE_ONE: want = LEN_WRITE_ONE;
			CMD_READ_MULTI: want = LEN_READ_MULTI;
			CMD_SELECT: want = LEN_SELECT;
			default: drop = 1'b1;
			endcase
			if (addr_mode && cmd != CMD_SELECT)
			begin
				want = want + UID_LEN;
				drop = drop | !uid_ok;
			end
			if (cur.crc != CRC_GOOD)
			begin
				drop = 1'b1;
			end
			if (cur.len != want || f[FLAG_INVENTORY])
			begin
				drop = 1'b1;
			end
			if (f[FLAG_SELECT] && (addr_mode || cur.tag != TAG_SELECTED))
			begin
				drop = 1'b1;
			end
			nx.st = ST_SEND;
			if (drop)
			begin
				nx.st = ST_IDLE;
				nx.busy = 1'b0;
			end
			else if (cmd == CMD_SELECT)
			begin
				if (!uid_ok)
				begin
					// silent, and a selected tag falls back to ready
					if (cur.tag == TAG_SELECTED)
					begin
						nx.tag = TAG_READY;
					end
					nx.st = ST_IDLE;
					nx.busy = 1'b0;
				end
				else if (f[FLAG_OPTION])
				begin
					nx.q = reply(RSP_ERR, ERR_OPTION);
				end
				else
				begin
					nx.tag = TAG_SELECTED;
					nx.q = reply(RSP_OK, 8'h00);
					nx.qn = 3'h1;
				end
			end
			else if (!f[FLAG_EXTEND])
			begin
				nx.q = reply(RSP_ERR, ERR_OTHER);
			end
			else if (bn > LAST_BLOCK)
			begin
				nx.q = reply(RSP_ERR, ERR_ABSENT);
			end
			else if (cmd == CMD_READ_MULTI && run_end > {1'b0, SECTOR_LAST})
			begin
				nx.q = reply(RSP_ERR, ERR_OTHER);
			end
			else
			begin
				if (cmd == CMD_READ_MULTI)
				begin
					nx.left = cur.rx[p + 5'h02][4:0];
				end
				nx.st = ST_EXEC;
			end
		end
		ST_EXEC:
		begin
			// security inputs now reflect the sector of the block
			nx.st = ST_SEND;
			if (cur.cmd == CMD_WRITE_ONE)
			begin
				if (write_deny_i)
				begin
					nx.q = reply(RSP_ERR, ERR_LOCKED);
				end
				else
				begin
					nx.mem_wr = 1'b1;
					nx.timer = 20'(PROG_CYCLES);
					nx.st = ST_PROG;
				end
			end
			else if (read_deny_i)
			begin
				nx.q = reply(RSP_ERR, ERR_RPROT);
				nx.left = 5'h00;
			end
			else
			begin
				nx.st = ST_FETCH;
			end
		end
		ST_FETCH:
		begin
			nx.mem_rd = 1'b1;
			nx.st = ST_LATCH;
		end
		ST_LATCH:
		begin
			nx.st = ST_GRAB;
		end
		ST_GRAB:
		begin
			nx.qn = 3'h4;
			if (cur.opt)
			begin
				qd = {qd[39:0], sec};
				nx.qn = nx.qn + 3'h1;
			end
			if (cur.head)
			begin
				qd = {qd[39:0], RSP_OK};
				nx.qn = nx.qn + 3'h1;
			end
			nx.q = qd;
			nx.head = 1'b0;
			nx.st = ST_SEND;
		end
		ST_PROG:
		begin
			// answer only once the program and verify cycle is over
			if (cur.timer == 20'h0)
			begin
				nx.st = ST_SEND;
				nx.qn = mem_ok_i ? 3'h1 : 3'h2;
				nx.q = mem_ok_i ? reply(RSP_OK, 8'h00) :
					reply(RSP_ERR, ERR_PROG);
			end
			else
			begin
				nx.timer = cur.timer - 20'h1;
			end
		end
		ST_SEND:
		begin
			if (!cur.tx_valid || tx_ready_i)
			begin
				nx.tx_valid = 1'b0;
				nx.tx_last = 1'b0;
				if (cur.qn != 3'h0)
				begin
					nx.tx_byte = cur.q[0];
					nx.tx_valid = 1'b1;
					nx.tx_last = (cur.qn == 3'h1) && (cur.left == 5'h00);
					nx.q = cur.q >> 8;
					nx.qn = cur.qn - 3'h1;
				end
				else if (cur.left != 5'h00)
				begin
					// next block of the run, same sector by construction
					nx.blk = cur.blk + 9'h001;
					nx.left = cur.left - 5'h01;
					nx.st = ST_FETCH;
				end
				else
				begin
					nx.st = ST_IDLE;
					nx.busy = 1'b0;
				end
			end
		end
		default:
		begin
			nx.st = ST_IDLE;
			nx.busy = 1'b0;
		end
		endcase
		// wip mode pulls low only across the program cycle
		nx.act_oe = wip_mode_i ? (nx.st == ST_PROG) : nx.busy;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			cur <= '0;
			cur.st <= ST_IDLE;
			cur.tag <= TAG_READY;
		end
		else
		begin
			cur <= nx;
		end
	end

	assign tx_byte_o = cur.tx_byte;
	assign tx_valid_o = cur.tx_valid;
	assign tx_last_o = cur.tx_last;
	assign tag_state_o = cur.tag;
	assign mem_addr_o = cur.blk;
	assign mem_rd_o = cur.mem_rd;
	assign mem_wr_o = cur.mem_wr;
	assign mem_wdata_o = cur.wdata;
	assign sector_o = cur.blk[8:5];
	// open drain: only ever pulls low
	assign act_o = 1'b0;
	assign act_oe_o = cur.act_oe;

endmodule

// ### tb/block_access_monitor.sv
`timescale 1ns/1ps
module block_access_monitor #(
	parameter int PROG_CYCLES = vcard_pkg::PROG_CYCLES
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// watched ports
	input wire logic wip_mode_i,
	input wire logic tx_valid_o,
	input wire logic tx_last_o,
	input wire logic mem_rd_o,
	input wire logic mem_wr_o,
	input wire logic [8:0] mem_addr_o,
	input wire logic [3:0] sector_o,
	input wire logic act_o,
	input wire logic act_oe_o,
	input wire vcard_pkg::tag_e tag_state_o
);
	import vcard_pkg::*;
	int wcnt;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);
	// cycles since the last program pulse, to time the write wait
	always_ff @(posedge sys_clk_i)
		wcnt <= (!rstn_i || mem_wr_o) ? 0 : wcnt + 1;
	logic in_run;
	logic [3:0] run_sector;
	// sector of the first block read since the last response ended
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i || tx_last_o)
			in_run <= 1'b0;
		else if (mem_rd_o)
			in_run <= 1'b1;
		if (mem_rd_o && !in_run)
			run_sector <= sector_o;
	end
	a_pin_low:
		assert property (act_o == 1'b0) else $error("pin high");
	a_busy_resp:
		assert property (!wip_mode_i && tx_valid_o |-> act_oe_o)
		else $error("busy gap");
	a_wip_idle:
		assert property (wip_mode_i && tx_valid_o |-> !act_oe_o)
		else $error("wip in response");
	a_wip_prog:
		assert property (wip_mode_i && mem_wr_o |-> ##[0:2] act_oe_o)
		else $error("wip missing");
	a_prog_wait:
		assert property (wip_mode_i && $fell(act_oe_o) |->
			wcnt >= PROG_CYCLES) else $error("wait short");
	a_wr_pulse:
		assert property (mem_wr_o |=> !mem_wr_o) else $error("long pulse");
	a_read_reply:
		assert property (mem_rd_o |-> ##[1:3] tx_valid_o)
		else $error("no reply");
	a_sector_addr:
		assert property (mem_rd_o && in_run |-> sector_o == run_sector)
		else $error("run left its sector");
	c_write: cover property (mem_wr_o);
	c_quiet: cover property (tag_state_o == TAG_QUIET);
	c_multi: cover property (mem_rd_o ##[1:8] mem_rd_o);
endmodule

bind block_access_core block_access_monitor #(
	.PROG_CYCLES(PROG_CYCLES)
) mon_u (
	.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .wip_mode_i(wip_mode_i),
	.tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
	.mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
	.mem_addr_o(mem_addr_o), .sector_o(sector_o), .act_o(act_o),
	.act_oe_o(act_oe_o), .tag_state_o(tag_state_o)
);

// ### tb/reader_model.sv
`timescale 1ns/1ps
module reader_model (
	// clock
	input wire logic sys_clk_i,
	// request to the tag
	output logic sof_i,
	output logic [7:0] rx_byte_i,
	output logic rx_valid_i,
	output logic eof_i,
	// response from the tag
	input wire logic [7:0] tx_byte_o,
	input wire logic tx_valid_o,
	input wire logic tx_last_o,
	output logic tx_ready_i
);
	logic [7:0] rsp[$];
	logic done = 0;
	logic [2:0] stall = 0;
	initial
	begin
		sof_i = 0;
		rx_byte_i = 0;
		rx_valid_i = 0;
		eof_i = 0;
		tx_ready_i = 0;
	end
	// stalls two cycles in eight so slow acceptance is exercised too
	always @(posedge sys_clk_i)
	begin
		stall <= stall + 3'h1;
		tx_ready_i <= stall[2:1] != 2'h0;
		if (tx_valid_o && tx_ready_i)
		begin
			rsp.push_back(tx_byte_o);
			done = tx_last_o;
		end
	end
	task automatic send(input logic [7:0] f[$]);
		@(posedge sys_clk_i);
		rsp.delete();
		done = 0;
		sof_i <= 1;
		foreach (f[i])
		begin
			@(posedge sys_clk_i);
			sof_i <= 0;
			rx_byte_i <= f[i];
			rx_valid_i <= 1;
			eof_i <= i == f.size() - 1;
		end
		@(posedge sys_clk_i);
		rx_valid_i <= 0;
		eof_i <= 0;
		rx_byte_i <= ~rx_byte_i;
	endtask
endmodule

// ### tb/rf_block_access_select_cmds_test.sv
`timescale 1ns/1ps
module rf_block_access_select_cmds_test;
	import vcard_pkg::*;
	logic sys_clk_i = 0;
	logic rstn_i = 0;
	logic sof_i, rx_valid_i, eof_i, tx_valid_o, tx_last_o, tx_ready_i;
	logic [7:0] rx_byte_i, tx_byte_o;
	logic [63:0] uid_i, tuid;
	logic wip_mode_i, go_quiet_i, mem_rd_o, mem_wr_o, mem_ok_i, o;
	logic read_deny_i, write_deny_i, act_o, act_oe_o;
	logic [8:0] mem_addr_o, b;
	logic [31:0] mem_wdata_o, mem_rdata_i, w, mem[512];
	logic [3:0] sector_o;
	logic [4:0] secv, s, n;
	logic [7:0] req[$], ex[$];
	tag_e tag_state_o;
	int seed, cyc, errors, n_checks;
	always #5 sys_clk_i = ~sys_clk_i;
	block_access_core #(.PROG_CYCLES(20)) dut_u (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sof_i(sof_i),
		.rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i), .eof_i(eof_i),
		.tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o),
		.tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i), .uid_i(uid_i),
		.wip_mode_i(wip_mode_i), .go_quiet_i(go_quiet_i),
		.tag_state_o(tag_state_o), .mem_addr_o(mem_addr_o),
		.mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
		.mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
		.mem_ok_i(mem_ok_i), .sector_o(sector_o), .sec_lock_i(secv[0]),
		.sec_rw_i(secv[2:1]), .sec_pwd_i(secv[4:3]),
		.read_deny_i(read_deny_i), .write_deny_i(write_deny_i),
		.act_o(act_o), .act_oe_o(act_oe_o)
	);
	reader_model rd_u (.sys_clk_i(sys_clk_i), .sof_i(sof_i),
		.rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i), .eof_i(eof_i),
		.tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o),
		.tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i));
	// block memory; read data toggles when not requested
	always @(posedge sys_clk_i)
	begin
		mem_rdata_i <= mem_rd_o ? mem[mem_addr_o] : ~mem_rdata_i;
		if (mem_wr_o)
			mem[mem_addr_o] <= mem_wdata_o;
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			errors++;
			complete_run();
		end
	end
	task complete_run;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (e !== g)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] c;
		c = CRC_PRESET;
		foreach (q[i])
		begin
			c ^= {8'h00, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction
	task automatic hdr(input logic [7:0] f, c);
		req = '{f, c};
		if (f[FLAG_ADDRESS])
			for (int i = 0; i < 8; i++)
				req.push_back(tuid[8*i +: 8]);
	endtask
	task automatic blk(input logic [8:0] v);
		req.push_back(v[7:0]);
		req.push_back({7'h00, v[8]});
	endtask
	task automatic dat(input logic [31:0] v);
		for (int k = 0; k < 4; k++)
			ex.push_back(v[8*k +: 8]);
	endtask
	task automatic run(input logic bad);
		logic [15:0] c;
		c = crc(req) ^ {15'h0000, bad};
		req.push_back(c[7:0]);
		req.push_back(c[15:8]);
		rd_u.send(req);
		repeat (600) if (!rd_u.done) @(negedge sys_clk_i);
		chk("length", ex.size(), rd_u.rsp.size());
		foreach (ex[i])
			chk("byte", ex[i], rd_u.rsp[i]);
		@(posedge sys_clk_i);
	endtask
	initial
	begin
		seed = 27393;
		uid_i = {$random(seed), $random(seed)};
		tuid = uid_i;
		{wip_mode_i, go_quiet_i, read_deny_i, write_deny_i} = 4'h0;
		mem_ok_i = 1;
		secv = 0;
		mem_rdata_i = 0;
		foreach (mem[i]) mem[i] = $random(seed);
		repeat (4) @(posedge sys_clk_i);
		rstn_i <= 1;
		for (int i = 0; i < 8; i++)
		begin
			b = i ? 9'($random(seed)) : 9'h1ff;
			{o, s} = 6'($random(seed));
			secv <= s;
			hdr({1'b0, o, i[0], 5'h08}, CMD_READ_ONE);
			blk(b);
			ex = '{RSP_OK};
			if (o) ex.push_back({3'h0, s});
			dat(mem[b]);
			run(0);
		end
		hdr(8'h00, CMD_READ_ONE);
		blk(0);
		ex = '{RSP_ERR, ERR_OTHER};
		run(0);
		hdr(8'h08, CMD_READ_ONE);
		req.push_back(8'h00);
		req.push_back(8'h02);
		ex = '{RSP_ERR, ERR_ABSENT};
		run(0);
		read_deny_i <= 1;
		hdr(8'h08, CMD_READ_ONE);
		blk(5);
		ex = '{RSP_ERR, ERR_RPROT};
		run(0);
		read_deny_i <= 0;
		hdr(8'h08, CMD_READ_ONE);
		blk(5);
		ex = {};
		run(1);
		$display("single reads done");
		wip_mode_i <= 1;
		for (int i = 0; i < 4; i++)
		begin
			b = i ? 9'($random(seed)) : 9'h1ff;
			w = $random(seed);
			mem_ok_i <= i != 2;
			write_deny_i <= i == 3;
			hdr(8'h08, CMD_WRITE_ONE);
			blk(b);
			for (int k = 0; k < 4; k++) req.push_back(w[8*k +: 8]);
			ex = '{RSP_OK};
			if (i > 1) ex = '{RSP_ERR, (i == 2) ? ERR_PROG : ERR_LOCKED};
			run(0);
			if (i < 2) chk("block", w, mem[b]);
		end
		$display("writes done");
		// reads and select in wip mode must leave the activity pin released
		{wip_mode_i, write_deny_i, mem_ok_i} <= 3'h5;
		for (int i = 0; i < 5; i++)
		begin
			b = i ? 9'($random(seed)) : 9'h1e0;
			s = 5'($random(seed));
			n = i ? 5'(s % (6'd32 - b[4:0])) : 5'h1f;
			secv <= s;
			hdr({1'b0, i[0], 6'h08}, CMD_READ_MULTI);
			blk(b);
			req.push_back({3'h0, n});
			ex = '{RSP_OK};
			for (int k = 0; k <= n; k++)
			begin
				if (i[0]) ex.push_back({3'h0, s});
				dat(mem[b + k]);
			end
			run(0);
		end
		hdr(8'h08, CMD_READ_MULTI);
		blk(9'h01f);
		req.push_back(8'h01);
		ex = '{RSP_ERR, ERR_OTHER};
		run(0);
		$display("multiple reads done");
		hdr(8'h28, CMD_SELECT);
		ex = '{RSP_OK};
		run(0);
		chk("state", TAG_SELECTED, tag_state_o);
		hdr(8'h68, CMD_SELECT);
		ex = '{RSP_ERR, ERR_OPTION};
		run(0);
		chk("state", TAG_SELECTED, tag_state_o);
		tuid = ~uid_i;
		hdr(8'h28, CMD_SELECT);
		ex = {};
		run(0);
		chk("state", TAG_READY, tag_state_o);
		hdr(8'h18, CMD_READ_ONE);
		blk(5);
		ex = {};
		run(0);
		tuid = uid_i;
		go_quiet_i <= 1;
		@(posedge sys_clk_i);
		go_quiet_i <= 0;
		@(negedge sys_clk_i);
		chk("state", TAG_QUIET, tag_state_o);
		hdr(8'h28, CMD_SELECT);
		ex = '{RSP_OK};
		run(0);
		chk("state", TAG_SELECTED, tag_state_o);
		hdr(8'h18, CMD_READ_ONE);
		blk(5);
		ex = '{RSP_OK};
		dat(mem[5]);
		run(0);
		$display("select done");
		complete_run();
	end
endmodule
